/* inc/sbo_link_if.sv */
`timescale 1ns/10ps
interface sbo_link_if;
  // Host to device: one ORB word per valid cycle
  logic orb_valid;
  logic [2:0] orb_idx;
  sbo_pkg::sbo_kind_type orb_kind;
  logic [31:0] orb_word;
  logic orb_last;
  // Device to host: response or status words
  logic rsp_valid;
  logic [2:0] rsp_idx;
  logic [31:0] rsp_word;
  logic rsp_is_status;
  logic [63:0] rsp_addr;
  modport host (output orb_valid, orb_idx, orb_kind, orb_word, orb_last,
    input rsp_valid, rsp_idx, rsp_word, rsp_is_status, rsp_addr);
  modport device (input orb_valid, orb_idx, orb_kind, orb_word, orb_last,
    output rsp_valid, rsp_idx, rsp_word, rsp_is_status, rsp_addr);
endinterface : sbo_link_if

/* inc/sbo_params.svh */
`ifndef SBO_PARAMS_SVH
`define SBO_PARAMS_SVH
// Function
// - Host puts password immediate, length zero
// - Host gives response buffer of twelve bytes
// - Host sets login notify bit to one
// - Host sets login request format zero
// - Host sets exclusive login bit one
// - Host zeroes reserved and function code
// - Reconnect time is two to field seconds
// - Host sets login unit number to one
// - Status goes to login status address
// - Response: byte count, login id, zero
// - Response carries agent base; host reuses id (host here only keeps it on login_id, in no later ORB)
// - Host sends text command with CR LF NUL
// - Notify bit one; device writes status block
// - Host zeroes send reserved and direction bits
// - Host sets send speed field to two
// - Host sets maximum payload field to nine
// - Device accepts page table flag either way
// - Page size zero unless page table set
// - Data size is buffer size, at least 80
// - Transfer length at least eighty
// - Unit one, reserved zero, event flag zero
// - Control byte is 128

// ------------------------------------------------------------
// Field positions in the flags word (word 4) of an ORB
// ------------------------------------------------------------
`define SBO_N_BIT 31
`define SBO_X_BIT 28
`define SBO_P_BIT 19
// Login, send and response field values
`define SBO_RESP_LEN 16'h000C
`define SBO_PASS_VALUE 64'h5254_4300_0000_0000
`define SBO_LOGIN_LUN 16'h0001
`define SBO_SPD_VALUE 3'h2
`define SBO_PAYLOAD_VALUE 4'h9
`define SBO_MIN_LEN 24'h000050
`define SBO_CONTROL_VALUE 8'h80
`define SBO_CDB_OPCODE 8'h0A
`define SBO_CDB_LUN 3'h1
// Status codes in the status block
`define SBO_ST_OK 8'h00
`define SBO_ST_BAD 8'h01
// Reconnect second tick at 20 MHz
`define SBO_SEC_NS 1000000000
`define SBO_CLK_NS 50
`define SBO_SEC_CYCLES (`SBO_SEC_NS / `SBO_CLK_NS)
`endif

/* inc/sbo_pkg.sv */
package sbo_pkg;
  // ORB kinds passed over the link
  typedef enum logic [1:0] {
    SBO_LOGIN = 2'h0,
    SBO_SEND = 2'h1,
    SBO_RECV = 2'h2
  } sbo_kind_type;
  // Words of an ORB, eight 32-bit words
  typedef logic [31:0] sbo_word_type;
endpackage : sbo_pkg

/* rtl/sbo_device.sv */
// Design decisions made here: the address map.
`timescale 1ns/10ps
`include "sbo_params.svh"
module sbo_device #(
  // Arbitrary agent base address
  parameter logic [63:0] AGENT_BASE = 64'h0000_FFFF_F001_0000,
  parameter int SEC_CYCLES = `SBO_SEC_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User side
  output logic logged_in,
  output logic orb_seen,
  output logic orb_ok,
  output logic [31:0] reconnect_secs,
  output logic [63:0] data_addr,
  output logic [15:0] data_size,
  // Link
  sbo_link_if.device link
);
  // ------------------------------------------------------------
  // ORB capture
  // ------------------------------------------------------------
  logic [31:0] w_reg [0:7];
  logic [31:0] w_next [0:7];
  logic [63:0] fifo_reg, fifo_next;
  logic [63:0] rbuf_reg, rbuf_next;
  logic [15:0] id_reg, id_next;
  logic login_reg, login_next;
  logic ok;
  logic [31:0] secs;
  // Reply sequencer
  typedef enum logic [2:0] {
    SBO_IDLE = 3'b001, SBO_RESP = 3'b010, SBO_STAT = 3'b100
  } sbo_st_type;
  sbo_st_type st_reg, st_next;
  logic [2:0] ri_reg, ri_next;
  sbo_pkg::sbo_kind_type k_reg, k_next;
  logic [31:0] rw;

  // Word store, one entry per index
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_w
      always_comb begin
        w_next[gi] = w_reg[gi];
        if (link.orb_valid && link.orb_idx == gi) w_next[gi] = link.orb_word;
      end
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) w_reg[gi] <= 32'h0;
        else w_reg[gi] <= w_next[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Field checks and reconnect time
  // ------------------------------------------------------------
  // Field check of the finished ORB, page flag either way
  always_comb begin
    if (k_reg == sbo_pkg::SBO_LOGIN)
      ok = w_reg[4][`SBO_N_BIT] && w_reg[4][`SBO_X_BIT]
        && w_reg[4][27:24] == 4'h0 && w_reg[4][19:16] == 4'h0
        && w_reg[4][15:0] == `SBO_LOGIN_LUN && w_reg[5][15:0] >= 16'hC;
    else
      ok = w_reg[4][`SBO_N_BIT] && w_reg[4][15:0] >= 16'h0050
        // Whole 24-bit transfer length, upper byte included
        && {w_reg[5][15:0], w_reg[6][31:24]} >= `SBO_MIN_LEN
        && w_reg[6][23:16] == `SBO_CONTROL_VALUE
        && (w_reg[4][`SBO_P_BIT] || w_reg[4][18:16] == 3'h0);
  end

  // Reconnect time, two to the field in seconds
  assign secs = 32'h1 << w_reg[4][23:20];

  // ------------------------------------------------------------
  // Reply words and sequencer
  // ------------------------------------------------------------
  // Response and status word for the reply index
  always_comb begin
    rw = 32'h0;
    if (st_reg == SBO_RESP) begin
      unique case (ri_reg)
        3'h0: rw = {`SBO_RESP_LEN, id_reg};
        3'h1: rw = AGENT_BASE[63:32];
        3'h2: rw = AGENT_BASE[31:0];
        default: rw = {16'h0, 16'h0};
      endcase
    end else if (st_reg == SBO_STAT) begin
      rw = {24'h0, ok ? `SBO_ST_OK : `SBO_ST_BAD};
    end
  end

  // Sequencer next-state
  always_comb begin
    st_next = st_reg;
    ri_next = ri_reg;
    k_next = k_reg;
    fifo_next = fifo_reg;
    rbuf_next = rbuf_reg;
    id_next = id_reg;
    login_next = login_reg;
    if (link.orb_valid) k_next = link.orb_kind;
    unique case (st_reg)
      SBO_IDLE: begin
        // Whole ORB held once its last word arrives
        if (link.orb_valid && link.orb_last) begin
          ri_next = 3'h0;
          if (link.orb_kind == sbo_pkg::SBO_LOGIN) begin
            st_next = SBO_RESP;
            fifo_next = {w_reg[6], link.orb_word};
            rbuf_next = {w_reg[2], w_reg[3]};
            id_next = id_reg + 16'h1;
          end else begin
            st_next = SBO_STAT;
          end
        end
      end
      SBO_RESP: begin
        ri_next = ri_reg + 3'h1;
        if (ri_reg == 3'h3) begin
          st_next = SBO_STAT;
          ri_next = 3'h0;
        end
      end
      SBO_STAT: begin
        st_next = SBO_IDLE;
        if (k_reg == sbo_pkg::SBO_LOGIN) login_next = ok;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Reply outputs, next values
  // ------------------------------------------------------------
  logic rsp_valid_next; // Word on the link next cycle
  logic [2:0] rsp_idx_next; // Index of that word
  logic [31:0] rsp_word_next; // Response or status word
  logic rsp_is_status_next; // Status block marker
  logic [63:0] rsp_addr_next; // Host address of the word
  logic orb_seen_next; // One-cycle status pulse
  logic orb_ok_next; // Pulse when fields were legal
  logic [31:0] secs_next; // Reconnect time to report
  logic [63:0] daddr_next; // Data buffer of last command
  logic [15:0] dsize_next; // Data size of last command

  // Outputs trail the sequencer by one cycle, all from flip-flops
  always_comb begin
    rsp_valid_next = st_reg != SBO_IDLE;
    rsp_idx_next = ri_reg;
    rsp_word_next = rw;
    rsp_is_status_next = st_reg == SBO_STAT;
    // Status always lands at the login status address
    rsp_addr_next = (st_reg == SBO_STAT) ? fifo_reg : rbuf_reg;
    orb_seen_next = st_reg == SBO_STAT;
    orb_ok_next = st_reg == SBO_STAT && ok;
    // Held values keep the last finished command
    secs_next = reconnect_secs;
    daddr_next = data_addr;
    dsize_next = data_size;
    // Reconnect time taken only from a finished login
    if (st_reg == SBO_STAT && k_reg == sbo_pkg::SBO_LOGIN) begin
      secs_next = secs;
    end
    // Buffer of a send or receive command
    if (st_reg == SBO_STAT && k_reg != sbo_pkg::SBO_LOGIN) begin
      daddr_next = {w_reg[2], w_reg[3]};
      dsize_next = w_reg[4][15:0];
    end
  end

  // Sequencer registers and registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SBO_IDLE;
      ri_reg <= 3'h0;
      k_reg <= sbo_pkg::SBO_LOGIN;
      fifo_reg <= 64'h0;
      rbuf_reg <= 64'h0;
      id_reg <= 16'h0;
      login_reg <= 1'b0;
      link.rsp_valid <= 1'b0;
      link.rsp_idx <= 3'h0;
      link.rsp_word <= 32'h0;
      link.rsp_is_status <= 1'b0;
      link.rsp_addr <= 64'h0;
      orb_seen <= 1'b0;
      orb_ok <= 1'b0;
      reconnect_secs <= 32'h1;
      data_addr <= 64'h0;
      data_size <= 16'h0;
    end else begin
      st_reg <= st_next;
      ri_reg <= ri_next;
      k_reg <= k_next;
      fifo_reg <= fifo_next;
      rbuf_reg <= rbuf_next;
      id_reg <= id_next;
      login_reg <= login_next;
      // Reply outputs, computed the cycle before
      link.rsp_valid <= rsp_valid_next;
      link.rsp_idx <= rsp_idx_next;
      link.rsp_word <= rsp_word_next;
      link.rsp_is_status <= rsp_is_status_next;
      link.rsp_addr <= rsp_addr_next;
      orb_seen <= orb_seen_next;
      orb_ok <= orb_ok_next;
      reconnect_secs <= secs_next;
      data_addr <= daddr_next;
      data_size <= dsize_next;
    end
  end

  assign logged_in = login_reg;
endmodule : sbo_device

/* rtl/sbo_host.sv */
`timescale 1ns/10ps
`include "sbo_params.svh"
module sbo_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User side
  input wire logic start,
  input wire sbo_pkg::sbo_kind_type kind,
  input wire logic [63:0] buf_addr,
  input wire logic [15:0] buf_size,
  input wire logic [63:0] fifo_addr,
  input wire logic [3:0] reconnect,
  input wire logic page_tbl,
  input wire logic [2:0] page_size,
  output logic busy,
  output logic [15:0] login_id,
  output logic [7:0] last_status,
  // Link
  sbo_link_if.host link
);
  // ------------------------------------------------------------
  // Sender state
  // ------------------------------------------------------------
  logic busy_reg, busy_next;
  logic [2:0] idx_reg, idx_next;
  sbo_pkg::sbo_kind_type kind_reg, kind_next;
  logic [15:0] id_reg, id_next;
  logic [7:0] st_reg, st_next;
  logic [31:0] word;
  logic [15:0] len;
  logic last_next; // Last ORB word goes out next cycle

  // Size clamped up to the least legal value
  assign len = (buf_size < 16'h0050) ? 16'h0050 : buf_size;

  // Word composer for the current ORB index
  always_comb begin
    word = 32'h0;
    if (kind_reg == sbo_pkg::SBO_LOGIN) begin
      unique case (idx_reg)
        // Password halves, cut on purpose to one word each
        3'h0: word = 32'(`SBO_PASS_VALUE >> 32);
        3'h1: word = 32'(`SBO_PASS_VALUE);
        3'h2: word = buf_addr[63:32];
        3'h3: word = buf_addr[31:0];
        // Notify one, fmt zero, exclusive one, function zero
        3'h4: word = {1'b1, 2'h0, 1'b1, 4'h0, reconnect, 4'h0,
          `SBO_LOGIN_LUN};
        3'h5: word = {16'h0, `SBO_RESP_LEN};
        3'h6: word = fifo_addr[63:32];
        default: word = fifo_addr[31:0];
      endcase
    end else begin
      unique case (idx_reg)
        3'h0: word = 32'h0;
        3'h1: word = 32'h1;
        // Buffer holds command text ended by CR LF NUL
        3'h2: word = buf_addr[63:32];
        3'h3: word = buf_addr[31:0];
        3'h4: word = {1'b1, 2'h0, 1'b0, 1'b0, `SBO_SPD_VALUE,
          `SBO_PAYLOAD_VALUE, page_tbl,
          page_tbl ? page_size : 3'h0, len};
        3'h5: word = {`SBO_CDB_OPCODE, `SBO_CDB_LUN, 4'h0, 1'b0,
          8'h0, len[15:8]};
        3'h6: word = {len[7:0], `SBO_CONTROL_VALUE, 16'h0};
        default: word = 32'h0;
      endcase
    end
  end

  // Next-state for sender and response capture
  always_comb begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    kind_next = kind_reg;
    id_next = id_reg;
    st_next = st_reg;
    last_next = busy_reg && idx_reg == 3'h7;
    if (!busy_reg && start) begin
      busy_next = 1'b1;
      idx_next = 3'h0;
      kind_next = kind;
    end else if (busy_reg) begin
      idx_next = idx_reg + 3'h1;
      if (idx_reg == 3'h7) busy_next = 1'b0;
    end
    // Login id captured from response word 0 for login_id
    if (link.rsp_valid && !link.rsp_is_status && link.rsp_idx == 3'h0)
      id_next = link.rsp_word[15:0];
    if (link.rsp_valid && link.rsp_is_status)
      st_next = link.rsp_word[7:0];
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      idx_reg <= 3'h0;
      kind_reg <= sbo_pkg::SBO_LOGIN;
      id_reg <= 16'h0;
      st_reg <= 8'h0;
      link.orb_valid <= 1'b0;
      link.orb_idx <= 3'h0;
      link.orb_kind <= sbo_pkg::SBO_LOGIN;
      link.orb_word <= 32'h0;
      link.orb_last <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
      kind_reg <= kind_next;
      id_reg <= id_next;
      st_reg <= st_next;
      link.orb_valid <= busy_reg;
      link.orb_idx <= idx_reg;
      link.orb_kind <= kind_reg;
      link.orb_word <= word;
      link.orb_last <= last_next;
    end
  end

  assign busy = busy_reg;
  assign login_id = id_reg;
  assign last_status = st_reg;
endmodule : sbo_host

/* sim/sbo_link_properties.sv */
`timescale 1ns/10ps
module sbo_link_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host to device
  input wire logic orb_valid,
  input wire logic [2:0] orb_idx,
  input wire sbo_pkg::sbo_kind_type orb_kind,
  input wire logic [31:0] orb_word,
  input wire logic orb_last,
  // Device to host
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_idx,
  input wire logic [31:0] rsp_word,
  input wire logic rsp_is_status,
  input wire logic [63:0] rsp_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Login ORB on the link
  wire logic lg = orb_kind == sbo_pkg::SBO_LOGIN;
  // Flags word on the link
  wire logic w4 = orb_valid && orb_idx == 3'h4;
  // Status address of latest login
  logic [63:0] fifo_reg;
  logic [63:0] fifo_next;
  // ------
  // Status address capture
  // ------
  always_comb begin
    fifo_next = fifo_reg;
    if (orb_valid && lg && orb_idx == 3'h6) begin
      fifo_next[63:32] = orb_word;
    end
    if (orb_valid && lg && orb_idx == 3'h7) begin
      fifo_next[31:0] = orb_word;
    end
  end
  // Cleared so stale address never matches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_reg <= 64'h0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end
  // Eight ORB words, then idle
  sequence s_words;
    orb_valid [*8] ##1 !orb_valid;
  endsequence
  // Four response words, then status
  sequence s_resp;
    (rsp_valid && !rsp_is_status) [*4] ##1 (rsp_valid && rsp_is_status);
  endsequence
  a_orb_burst: assert property ($rose(orb_valid) |-> s_words)
    else $error("ORB burst length wrong");
  a_last_idx: assert property (orb_valid |-> orb_last == (orb_idx == 3'h7))
    else $error("Last word flag misplaced");
  a_login_resp: assert property (
    orb_valid && orb_last && lg |-> ##2 s_resp)
    else $error("Login response sequence wrong");
  a_send_status: assert property (
    orb_valid && orb_last && !lg |-> ##2 rsp_valid && rsp_is_status)
    else $error("Status block missing");
  a_resp_fields: assert property (
    rsp_valid && !rsp_is_status |->
    (rsp_idx != 3'h0 || rsp_word[31:16] == 16'h000C) &&
    (rsp_idx != 3'h3 || rsp_word[31:16] == 16'h0000))
    else $error("Response length or reserved wrong");
  a_status_addr: assert property (
    rsp_valid && rsp_is_status |-> rsp_addr == fifo_reg)
    else $error("Status address wrong");
  a_login_flags: assert property (
    w4 && lg |-> orb_word[31:24] == 8'h90 && orb_word[19:0] == 20'h00001)
    else $error("Login flags wrong");
  a_password_imm: assert property (
    orb_valid && lg && orb_idx == 3'h0 |->
    orb_word == 32'h5254_4300 ##1 orb_word == 32'h0000_0000)
    else $error("Password wrong");
  a_login_lens: assert property (
    orb_valid && lg && orb_idx == 3'h5 |->
    orb_word[31:16] == 16'h0000 && orb_word[15:0] >= 16'h000C)
    else $error("Login lengths wrong");
  a_send_flags: assert property (
    w4 && !lg |-> orb_word[31:20] == 12'h829 &&
    (orb_word[19] || orb_word[18:16] == 3'h0) && orb_word[15:0] >= 16'h0050)
    else $error("Send flags wrong");
  a_cdb_fields: assert property (
    orb_valid && !lg && orb_idx == 3'h5 |->
    orb_word[31:16] == 16'h0A20 ##1 orb_word[23:16] == 8'h80)
    else $error("Command block fields wrong");
endmodule : sbo_link_properties

/* sim/sbp2_orb_login_send_receive_tb.sv */
`timescale 1ns/10ps
module sbp2_orb_login_send_receive_tb;
  // ------
  // Stimulus and outputs
  // ------
  localparam logic [63:0] BASE = 64'h0000_1234_5678_0000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  sbo_pkg::sbo_kind_type kind = sbo_pkg::SBO_LOGIN;
  logic [63:0] buf_addr = 64'h0;
  logic [15:0] buf_size = 16'h0;
  logic [63:0] fifo_addr = 64'h0;
  logic [3:0] reconnect = 4'h0;
  logic page_tbl = 1'b0;
  logic [2:0] page_size = 3'h0;
  logic busy, logged_in, orb_seen, orb_ok;
  logic [15:0] login_id, data_size;
  logic [7:0] last_status;
  logic [31:0] reconnect_secs;
  logic [63:0] data_addr, exp_fifo;
  // Model state: last response, counts
  logic [31:0] resp [4];
  logic [63:0] st_addr;
  int st_cnt = 0;
  int ok_cnt = 0;
  int seen_cnt = 0;
  int n_log = 0;
  int last_id, r;
  int n_errors = 0;
  int comparisons = 0;
  sbo_link_if link ();
  sbo_host u_sbo_host (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
    .kind(kind), .buf_addr(buf_addr), .buf_size(buf_size),
    .fifo_addr(fifo_addr), .reconnect(reconnect), .page_tbl(page_tbl),
    .page_size(page_size), .busy(busy), .login_id(login_id),
    .last_status(last_status), .link(link.host));
  // Short second passed in; the device never reads SEC_CYCLES
  sbo_device #(.AGENT_BASE(BASE), .SEC_CYCLES(20)) u_sbo_device (
    .ref_clk(ref_clk), .rst_n(rst_n), .logged_in(logged_in),
    .orb_seen(orb_seen), .orb_ok(orb_ok), .reconnect_secs(reconnect_secs),
    .data_addr(data_addr), .data_size(data_size), .link(link.device));
  sbo_link_properties u_sbo_link_properties (.ref_clk(ref_clk),
    .rst_n(rst_n), .orb_valid(link.orb_valid), .orb_idx(link.orb_idx),
    .orb_kind(link.orb_kind), .orb_word(link.orb_word),
    .orb_last(link.orb_last), .rsp_valid(link.rsp_valid),
    .rsp_idx(link.rsp_idx), .rsp_word(link.rsp_word),
    .rsp_is_status(link.rsp_is_status), .rsp_addr(link.rsp_addr));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ------
  // Link monitor
  // ------
  always @(posedge ref_clk) begin
    if (orb_ok) begin
      ok_cnt++;
    end
    // Every finished ORB shows one status pulse
    if (orb_seen) begin
      seen_cnt++;
    end
    if (link.rsp_valid && link.rsp_is_status) begin
      st_addr = link.rsp_addr;
      st_cnt++;
    end else if (link.rsp_valid) begin
      resp[link.rsp_idx[1:0]] = link.rsp_word;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("Errors %0d, checks %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // One ORB through both ends, then checks
  task automatic op(input sbo_pkg::sbo_kind_type k, input int rc,
    input int sz);
    int n0;
    int k0;
    int s0;
    int i;
    logic [63:0] ba;
    n0 = st_cnt;
    k0 = ok_cnt;
    s0 = seen_cnt;
    ba = {$urandom, $urandom};
    @(posedge ref_clk);
    kind <= k;
    reconnect <= rc[3:0];
    page_tbl <= rc[1];
    page_size <= {2'h0, rc[1]};
    buf_size <= sz[15:0];
    buf_addr <= ba;
    start <= 1'b1;
    if (k == sbo_pkg::SBO_LOGIN) begin
      exp_fifo = {$urandom, $urandom};
      fifo_addr <= exp_fifo;
    end
    @(posedge ref_clk);
    start <= 1'b0;
    for (i = 0; i < 60 && st_cnt == n0; i++) begin
      @(posedge ref_clk);
    end
    if (st_cnt == n0) begin
      n_errors++;
      test_done();
    end
    // Gap lets registered outputs settle before the checks
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(st_addr, exp_fifo);
    check(last_status, 8'h00);
    check(seen_cnt, s0 + 1);
    check(busy, 1'b0);
    if (k == sbo_pkg::SBO_LOGIN) begin
      check(resp[0][31:16], 16'h000C);
      check(resp[3][31:16], 16'h0000);
      check({resp[1], resp[2]}, BASE);
      check(login_id, resp[0][15:0]);
      if (n_log > 0) begin
        check(resp[0][15:0], 16'(last_id + 1));
      end
      last_id = resp[0][15:0];
      n_log++;
      check(logged_in, 1'b1);
      check(reconnect_secs, 32'h1 << rc);
    end else begin
      check(ok_cnt, k0 + 1);
      check(data_addr, ba);
      check(data_size, (sz < 80) ? 80 : sz);
    end
  endtask : op
  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(32'hA6F5));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (r = 0; r < 16; r++) begin
      op(sbo_pkg::SBO_LOGIN, r, 12 + r);
    end
    // Both kinds, page table off and on
    for (r = 0; r < 8; r++) begin
      op(r[0] ? sbo_pkg::SBO_RECV : sbo_pkg::SBO_SEND, r,
        r[2] ? 79 : $urandom_range(65535, 80));
    end
    test_done();
  end
endmodule : sbp2_orb_login_send_receive_tb
